// ===== core/tisr_pkg.sv
// Constants for the touch controller I2C slave and status registers
package tisr_pkg;
   // Bus address
   localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2B;
   localparam logic [7:0] NVM_ADDR_LOCATION = 8'h04;
   // Register offsets
   localparam logic [7:0] REG_INTERRUPT_SOURCE = 8'h00;
   localparam logic [7:0] REG_WHEEL_STATUS = 8'h01;
   localparam logic [7:0] REG_BUTTON_STATUS = 8'h02;
   localparam logic [7:0] REG_WHEEL_POSITION_HIGH = 8'h03;
   localparam logic [7:0] REG_WHEEL_POSITION_LOW = 8'h04;
   localparam logic [7:0] REG_INPUT_PIN_STATUS = 8'h07;
   localparam logic [7:0] REG_PARAM_MEMORY_STATUS = 8'h08;
   localparam logic [7:0] REG_COMPENSATION_AND_OP_MODE = 8'h09;
   localparam logic [7:0] REG_OUTPUT_PIN_CONTROL = 8'h0A;
   localparam logic [7:0] REG_DIMMABLE_PIN_SELECT = 8'h0B;
   localparam logic [7:0] REG_DIMMABLE_PIN_INTENSITY = 8'h0C;
   localparam logic [7:0] REG_PARAM_GATEWAY_CONFIG = 8'h0D;
   localparam logic [7:0] REG_PARAM_GATEWAY_BASE = 8'h0E;
   localparam logic [7:0] REG_PARAM_KEY_HIGH = 8'hAC;
   localparam logic [7:0] REG_PARAM_KEY_LOW = 8'hAD;
   localparam logic [7:0] REG_SOFTWARE_RESET = 8'hB1;
   // Interrupt source flag positions
   localparam int FLAG_OP_MODE = 0;
   localparam int FLAG_COMPENSATION = 1;
   localparam int FLAG_BUTTON = 2;
   localparam int FLAG_WHEEL = 3;
   localparam int FLAG_INPUT_PIN = 4;
   localparam int FLAG_PARAM_WRITE = 5;
   localparam int FLAG_NVM_BURN = 6;
   // Wheel status bit positions
   localparam int WHEEL_BIT_CW = 6;
   localparam int WHEEL_BIT_CCW = 5;
   localparam int WHEEL_BIT_TOUCH = 4;
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_POSITION = 16'h0000;
   localparam logic [6:0] RESET_FLAGS = 7'h00;
   // Byte framing
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] MSB_BIT = 3'h7;
   localparam logic [7:0] POINTER_STEP = 8'h01;

   // Link state machine
   typedef enum logic [2:0] {
      TISR_IDLE = 3'b000,
      TISR_ADDR = 3'b001,
      TISR_ADDR_ACK = 3'b010,
      TISR_RX = 3'b011,
      TISR_RX_ACK = 3'b100,
      TISR_TX = 3'b101,
      TISR_TX_ACK = 3'b110
   } tisr_state_e;
endpackage : tisr_pkg

// ===== core/tisr_slave.sv
// I2C slave with status, interrupt source and control registers
// How it works
// - Slave only; link edges found by oversampling, fine for 100 and 400 kb/s.
// - Answers 7-bit address 2B unless the memory-held address is marked valid.
// - Written control values go to the core only at each processing phase start.
// - Write: address with bit 0, ack, register address, ack, acked data, stop.
// - Register pointer steps by one after every data byte, read or write.
// - Device acks read address, sends bytes until master nacks then stops.
// - Status at 00-04 and 07-08, control at 09-0E, AC, AD, B1; rest reserved.
// - Interrupt source holds seven sticky flags in bits 6..0, bit 7 reads zero.
// - Interrupt output is low while any interrupt source flag is set.
// - Reading interrupt source clears all flags and releases the interrupt output.
// - Flags follow event pulses from the sensing core, up to one scan late.
// - Bit 6 on memory burn done, bit 5 on parameter write effective.
// - Bit 4 on configured input pin edge; pin details in input status.
// - Bit 3 on any wheel event: touch, release, rotation, position change.
// - Bit 2 on button touch, or release when release reporting is enabled.
// - Bit 1 when offset compensation completes, automatic or host requested.
// - Bit 0 on actual entry into active or doze mode.
// - Wheel status: clockwise bit 6, counter-clockwise bit 5, touched bit 4.
// - Wheel position 16-bit unsigned split high and low byte, read live from the core input, not reset here.
// - Input status shows level of pins in input mode, other pins read zero.
`timescale 1ns/1ps
`default_nettype none
module tisr_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address from non-volatile memory
   input wire logic [6:0] nvm_slave_addr,
   input wire logic nvm_addr_valid,
   // Sensing core status
   input wire logic wheel_cw,
   input wire logic wheel_ccw,
   input wire logic wheel_touched,
   input wire logic [7:0] buttons_touched,
   input wire logic [15:0] wheel_position,
   input wire logic [7:0] input_pin_levels,
   input wire logic [7:0] input_pin_mode,
   input wire logic [7:0] param_memory_status,
   input wire logic [7:0] op_mode_status,
   input wire logic [7:0] dimmable_intensity_rd,
   // Sensing core events, one-cycle pulses, plus the release report enable level
   input wire logic evt_nvm_burn_done,
   input wire logic evt_param_write_done,
   input wire logic evt_input_edge,
   input wire logic evt_wheel,
   input wire logic evt_button_touch,
   input wire logic evt_button_release,
   input wire logic button_release_report_en,
   input wire logic evt_compensation_done,
   input wire logic evt_mode_entry,
   // Processing phase
   input wire logic phase_start,
   // Applied control values
   output logic [7:0] compensation_and_op_mode,
   output logic [7:0] output_pin_control,
   output logic [7:0] dimmable_pin_select,
   output logic [7:0] dimmable_pin_intensity,
   output logic [7:0] param_gateway_config,
   output logic [7:0] param_gateway_base,
   output logic [7:0] param_key_high,
   output logic [7:0] param_key_low,
   output logic [7:0] software_reset,
   // Interrupt
   output logic interrupt_out_n
);
   // Pin synchronisers
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;
   // Third stage only feeds the edge and start/stop detectors
   always_ff @(posedge clk) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;

   // Own address picked from memory when valid
   wire [6:0] own_addr = nvm_addr_valid ? nvm_slave_addr : tisr_pkg::DEFAULT_SLAVE_ADDR;

   tisr_pkg::tisr_state_e state, next_state;
   logic [7:0] shift;
   logic [2:0] bit_cnt;
   logic reading;
   logic have_ptr;
   logic [7:0] ptr;
   logic [7:0] tx_byte;
   logic master_ack;
   logic ack_phase;
   logic [6:0] flags;

   // Staged host writes, applied at the phase start
   logic [7:0] stage [0:8];
   logic [8:0] stage_dirty;

   wire [7:0] rx_byte = {shift[6:0], sda_s};
   wire byte_done = (state == tisr_pkg::TISR_ADDR || state == tisr_pkg::TISR_RX) &&
      scl_rise && bit_cnt == tisr_pkg::LAST_BIT;
   wire addr_match = rx_byte[7:1] == own_addr;
   wire data_byte_rx = byte_done && state == tisr_pkg::TISR_RX && have_ptr;

   // Ack states are entered at the 8th rise; pulling then would fake a start.
   // Phase 0 waits out the 8th bit, phase 1 is the ack bit itself.
   wire in_ack = state == tisr_pkg::TISR_ADDR_ACK || state == tisr_pkg::TISR_RX_ACK;
   wire ack_end = in_ack && scl_fall && ack_phase;

   // Read decode
   // Reserved and unmapped offsets read as zero
   wire [7:0] wheel_status_val = {1'b0, wheel_cw, wheel_ccw, wheel_touched, 4'h0};
   wire [7:0] input_status_val = input_pin_levels & input_pin_mode;
   logic [7:0] read_val;
   always_comb begin
      case (ptr)
         tisr_pkg::REG_INTERRUPT_SOURCE: read_val = {1'b0, flags};
         tisr_pkg::REG_WHEEL_STATUS: read_val = wheel_status_val;
         tisr_pkg::REG_BUTTON_STATUS: read_val = buttons_touched;
         tisr_pkg::REG_WHEEL_POSITION_HIGH: read_val = wheel_position[15:8];
         tisr_pkg::REG_WHEEL_POSITION_LOW: read_val = wheel_position[7:0];
         tisr_pkg::REG_INPUT_PIN_STATUS: read_val = input_status_val;
         tisr_pkg::REG_PARAM_MEMORY_STATUS: read_val = param_memory_status;
         tisr_pkg::REG_COMPENSATION_AND_OP_MODE: read_val = op_mode_status;
         tisr_pkg::REG_OUTPUT_PIN_CONTROL: read_val = stage[1];
         tisr_pkg::REG_DIMMABLE_PIN_SELECT: read_val = stage[2];
         tisr_pkg::REG_DIMMABLE_PIN_INTENSITY: read_val = dimmable_intensity_rd;
         tisr_pkg::REG_PARAM_GATEWAY_CONFIG: read_val = stage[4];
         tisr_pkg::REG_PARAM_GATEWAY_BASE: read_val = stage[5];
         tisr_pkg::REG_PARAM_KEY_HIGH: read_val = stage[6];
         tisr_pkg::REG_PARAM_KEY_LOW: read_val = stage[7];
         tisr_pkg::REG_SOFTWARE_RESET: read_val = stage[8];
         default: read_val = tisr_pkg::RESET_BYTE;
      endcase
   end


   // Write decode into stage slot
   // Status, reserved and unmapped offsets are acked and dropped
   logic [3:0] wr_slot;
   logic wr_hit;
   always_comb begin
      wr_hit = 1'b1;
      case (ptr)
         tisr_pkg::REG_COMPENSATION_AND_OP_MODE: wr_slot = 4'h0;
         tisr_pkg::REG_OUTPUT_PIN_CONTROL: wr_slot = 4'h1;
         tisr_pkg::REG_DIMMABLE_PIN_SELECT: wr_slot = 4'h2;
         tisr_pkg::REG_DIMMABLE_PIN_INTENSITY: wr_slot = 4'h3;
         tisr_pkg::REG_PARAM_GATEWAY_CONFIG: wr_slot = 4'h4;
         tisr_pkg::REG_PARAM_GATEWAY_BASE: wr_slot = 4'h5;
         tisr_pkg::REG_PARAM_KEY_HIGH: wr_slot = 4'h6;
         tisr_pkg::REG_PARAM_KEY_LOW: wr_slot = 4'h7;
         tisr_pkg::REG_SOFTWARE_RESET: wr_slot = 4'h8;
         default: begin
            wr_slot = 4'h0;
            wr_hit = 1'b0;
         end
      endcase
   end

   // Loading a read byte at the ack fall; pointer 00 load clears flags

   wire load_tx = scl_fall && ((state == tisr_pkg::TISR_ADDR_ACK && ack_end && reading) ||
      (state == tisr_pkg::TISR_TX_ACK && master_ack));
   wire irq_read = load_tx && ptr == tisr_pkg::REG_INTERRUPT_SOURCE;

   // Protocol state machine
   always_comb begin
      next_state = state;
      if (stop_seen) begin
         next_state = tisr_pkg::TISR_IDLE;
      end else if (start_seen) begin
         next_state = tisr_pkg::TISR_ADDR;
      end else begin
         case (state)
            tisr_pkg::TISR_IDLE: next_state = tisr_pkg::TISR_IDLE;
            tisr_pkg::TISR_ADDR: begin
               if (byte_done) begin
                  next_state = addr_match ? tisr_pkg::TISR_ADDR_ACK : tisr_pkg::TISR_IDLE;
               end
            end
            tisr_pkg::TISR_ADDR_ACK: begin
               if (ack_end) begin
                  next_state = reading ? tisr_pkg::TISR_TX : tisr_pkg::TISR_RX;
               end
            end
            tisr_pkg::TISR_RX_ACK: begin
               if (ack_end) begin
                  next_state = tisr_pkg::TISR_RX;
               end
            end
            tisr_pkg::TISR_RX: begin
               if (byte_done) begin
                  next_state = tisr_pkg::TISR_RX_ACK;
               end
            end
            tisr_pkg::TISR_TX: begin
               if (scl_fall && bit_cnt == tisr_pkg::LAST_BIT) begin
                  next_state = tisr_pkg::TISR_TX_ACK;
               end
            end
            tisr_pkg::TISR_TX_ACK: begin
               if (scl_fall) begin
                  next_state = master_ack ? tisr_pkg::TISR_TX : tisr_pkg::TISR_IDLE;
               end
            end
            default: next_state = tisr_pkg::TISR_IDLE;
         endcase
      end
   end


   // Start and stop override any state, even in mid byte
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= tisr_pkg::TISR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Bit and byte tracking
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         shift <= tisr_pkg::RESET_BYTE;
         bit_cnt <= 3'h0;
         reading <= 1'b0;
         have_ptr <= 1'b0;
         ptr <= tisr_pkg::RESET_BYTE;
         tx_byte <= tisr_pkg::RESET_BYTE;
         master_ack <= 1'b0;
         ack_phase <= 1'b0;
      end else begin
         if (start_seen || stop_seen) begin
            bit_cnt <= 3'h0;
            ack_phase <= 1'b0;
            have_ptr <= 1'b0;
         end else if (scl_rise && (state == tisr_pkg::TISR_ADDR || state == tisr_pkg::TISR_RX)) begin
            shift <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (byte_done && state == tisr_pkg::TISR_ADDR) begin
            reading <= rx_byte[0];
         end
         // Pointer wraps past FF; no range check
         if (byte_done && state == tisr_pkg::TISR_RX) begin
            if (!have_ptr) begin
               ptr <= rx_byte;
               have_ptr <= 1'b1;
            end else begin
               ptr <= ptr + tisr_pkg::POINTER_STEP;
            end
         end
         // Two falls per ack state, so the phase is back at 0 on leaving
         if (in_ack && scl_fall) begin
            ack_phase <= ~ack_phase;
         end
         if (load_tx) begin
            tx_byte <= read_val;
            ptr <= ptr + tisr_pkg::POINTER_STEP;
            bit_cnt <= 3'h0;
         end else if (state == tisr_pkg::TISR_TX && scl_fall) begin
            // Next bit goes out in the low phase, settled long before the rise
            tx_byte <= {tx_byte[6:0], 1'b0};
            bit_cnt <= bit_cnt + 3'h1;
         end
         // Master's answer taken at the rise of the ack bit
         if (state == tisr_pkg::TISR_TX_ACK && scl_rise) begin
            master_ack <= ~sda_s;
         end
      end
   end


   // Pull only inside the ack bit or a 0 data bit, set and released only after clock falls
   wire drive_ack = in_ack && ack_phase;
   wire drive_data = (state == tisr_pkg::TISR_TX) && !tx_byte[tisr_pkg::MSB_BIT];
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= drive_ack || drive_data;
      end
   end
   // Open drain: the line is only ever pulled low
   assign sda_out = 1'b0;


   // Sticky flags; an event in the clearing cycle survives
   wire [6:0] flag_set;
   assign flag_set[tisr_pkg::FLAG_NVM_BURN] = evt_nvm_burn_done;
   assign flag_set[tisr_pkg::FLAG_PARAM_WRITE] = evt_param_write_done;
   assign flag_set[tisr_pkg::FLAG_INPUT_PIN] = evt_input_edge;
   assign flag_set[tisr_pkg::FLAG_WHEEL] = evt_wheel;
   assign flag_set[tisr_pkg::FLAG_BUTTON] = evt_button_touch |
      (evt_button_release & button_release_report_en);
   assign flag_set[tisr_pkg::FLAG_COMPENSATION] = evt_compensation_done;
   assign flag_set[tisr_pkg::FLAG_OP_MODE] = evt_mode_entry;
   // Set wins over the read clear in the same cycle
   wire [6:0] next_flags = (irq_read ? tisr_pkg::RESET_FLAGS : flags) | flag_set;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flags <= tisr_pkg::RESET_FLAGS;
      end else begin
         flags <= next_flags;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= ~|next_flags;
      end
   end


   // Staging and application at phase start
   // Core sees all staged bytes at once; a phase start mid-burst applies only the bytes received so far
   wire stage_we = data_byte_rx && wr_hit;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 9; i++) begin
            stage[i] <= tisr_pkg::RESET_BYTE;
         end
         stage_dirty <= 9'h000;
      end else begin
         if (phase_start) begin
            stage_dirty <= 9'h000;
         end
         if (stage_we) begin
            stage[wr_slot] <= rx_byte;
            stage_dirty[wr_slot] <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         compensation_and_op_mode <= tisr_pkg::RESET_BYTE;
         output_pin_control <= tisr_pkg::RESET_BYTE;
         dimmable_pin_select <= tisr_pkg::RESET_BYTE;
         dimmable_pin_intensity <= tisr_pkg::RESET_BYTE;
         param_gateway_config <= tisr_pkg::RESET_BYTE;
         param_gateway_base <= tisr_pkg::RESET_BYTE;
         param_key_high <= tisr_pkg::RESET_BYTE;
         param_key_low <= tisr_pkg::RESET_BYTE;
         software_reset <= tisr_pkg::RESET_BYTE;
      end else if (phase_start) begin
         compensation_and_op_mode <= stage[0];
         output_pin_control <= stage[1];
         dimmable_pin_select <= stage[2];
         dimmable_pin_intensity <= stage[3];
         param_gateway_config <= stage[4];
         param_gateway_base <= stage[5];
         param_key_high <= stage[6];
         param_key_low <= stage[7];
         software_reset <= stage[8];
      end
   end
endmodule : tisr_slave
`default_nettype wire

// ===== verif/tisr_slave_checker.sv
// Concurrent checks on the touch controller slave ports
`timescale 1ns/1ps
`default_nettype none
module tisr_slave_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Events and phase
   input wire logic evt_nvm_burn_done,
   input wire logic evt_param_write_done,
   input wire logic evt_input_edge,
   input wire logic evt_wheel,
   input wire logic evt_button_touch,
   input wire logic evt_button_release,
   input wire logic button_release_report_en,
   input wire logic evt_compensation_done,
   input wire logic evt_mode_entry,
   input wire logic phase_start,
   // Applied controls and interrupt
   input wire logic [7:0] output_pin_control,
   input wire logic [7:0] dimmable_pin_select,
   input wire logic [7:0] param_key_high,
   input wire logic [7:0] param_key_low,
   input wire logic [7:0] software_reset,
   input wire logic interrupt_out_n
);
   wire logic any_evt;
   wire logic [39:0] ctrl;
   assign any_evt = evt_nvm_burn_done | evt_param_write_done | evt_input_edge | evt_wheel | evt_button_touch
      | evt_compensation_done | evt_mode_entry | (evt_button_release & button_release_report_en);
   assign ctrl = {output_pin_control, dimmable_pin_select, param_key_high, param_key_low, software_reset};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_od_low_only: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
   a_idle_quiet: assert property ((scl_in && sda_in) [*4] |-> !sda_oe)
      else $error("data line pulled on idle bus");
   a_irq_set: assert property (any_evt |=> !interrupt_out_n)
      else $error("event did not pull interrupt low");
   a_irq_cause: assert property ($fell(interrupt_out_n) |-> $past(any_evt))
      else $error("interrupt without event");
   a_rel_gated: assert property (evt_button_release && !button_release_report_en && interrupt_out_n && !any_evt
      |=> interrupt_out_n)
      else $error("unreported release raised interrupt");
   // Clearing needs a clock edge of a read, so a quiet link keeps flags
   a_irq_sticky: assert property ((!interrupt_out_n && $stable(scl_in)) [*6] |=> !interrupt_out_n)
      else $error("interrupt released without read");
   a_ctrl_phase: assert property ($changed(ctrl) |-> $past(phase_start))
      else $error("control applied outside processing phase");
endmodule : tisr_slave_checker

bind tisr_slave tisr_slave_checker tisr_slave_checker_inst (.clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe,
   .evt_nvm_burn_done, .evt_param_write_done, .evt_input_edge, .evt_wheel, .evt_button_touch,
   .evt_button_release, .button_release_report_en, .evt_compensation_done, .evt_mode_entry, .phase_start,
   .output_pin_control, .dimmable_pin_select, .param_key_high, .param_key_low, .software_reset,
   .interrupt_out_n);
`default_nettype wire

// ===== verif/tisr_host_model.sv
// Host bus master model for the touch controller link
`timescale 1ns/1ps
`default_nettype none
module tisr_host_model (
   // Link wires
   output logic scl,
   output logic sda_drive,
   input wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_drive = 1'b1;
   end

   // Long low phase so the slave's late answer settles before the rise
   task automatic bit_cycle(input logic b, output logic s);
      scl = 1'b0;
      #10 sda_drive = b;
      #50 scl = 1'b1;
      #10 s = sda_wire;
      #10;
   endtask : bit_cycle

   // Long high phases let the oversampler see the data change
   task automatic start_cond;
      #3 scl = 1'b0;
      #10 sda_drive = 1'b1;
      #50 scl = 1'b1;
      #60 sda_drive = 1'b0;
      #60;
   endtask : start_cond

   task automatic stop_cond;
      scl = 1'b0;
      #10 sda_drive = 1'b0;
      #50 scl = 1'b1;
      #60 sda_drive = 1'b1;
      #60;
   endtask : stop_cond

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask : wbyte

   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(last, s);
   endtask : rbyte
endmodule : tisr_host_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the touch controller slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, reset_n, nvm_addr_valid, wheel_cw, wheel_ccw, wheel_touched, button_release_report_en, a;
   logic [6:0] nvm_slave_addr, dev_addr;
   logic [7:0] buttons_touched, input_pin_levels, input_pin_mode, param_memory_status, op_mode_status;
   logic [7:0] dimmable_intensity_rd;
   logic [15:0] wheel_position;
   logic [8:0] evt;
   logic [7:0] compensation_and_op_mode, output_pin_control, dimmable_pin_select, dimmable_pin_intensity;
   logic [7:0] param_gateway_config, param_gateway_base, param_key_high, param_key_low, software_reset;
   logic sda_out, sda_oe, interrupt_out_n;
   wire logic scl_in, sda_drive, sda_wire;
   int err_count = 0, comparisons = 0, cycles = 0;

   // Open drain with pull-up
   assign sda_wire = sda_drive & ~(sda_oe & ~sda_out);

   tisr_slave tisr_slave_inst (.clk, .reset_n, .scl_in, .sda_in(sda_wire), .sda_out, .sda_oe, .nvm_slave_addr,
      .nvm_addr_valid, .wheel_cw, .wheel_ccw, .wheel_touched, .buttons_touched, .wheel_position,
      .input_pin_levels, .input_pin_mode, .param_memory_status, .op_mode_status, .dimmable_intensity_rd,
      .evt_mode_entry(evt[0]), .evt_compensation_done(evt[1]), .evt_button_touch(evt[2]), .evt_wheel(evt[3]),
      .evt_input_edge(evt[4]), .evt_param_write_done(evt[5]), .evt_nvm_burn_done(evt[6]),
      .evt_button_release(evt[7]), .button_release_report_en, .phase_start(evt[8]), .compensation_and_op_mode,
      .output_pin_control, .dimmable_pin_select, .dimmable_pin_intensity, .param_gateway_config,
      .param_gateway_base, .param_key_high, .param_key_low, .software_reset, .interrupt_out_n);

   tisr_host_model tisr_host_model_inst (.scl(scl_in), .sda_drive(sda_drive), .sda_wire(sda_wire));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // Transfers take about 320 to 420 cycles each
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic pulse(input logic [8:0] m);
      @(posedge clk);
      #1 evt = m;
      @(posedge clk);
      #1 evt = 9'h000;
   endtask : pulse

   task automatic send(input logic [7:0] d);
      logic ack;
      tisr_host_model_inst.wbyte(d, ack);
      check({7'h00, ack}, 8'h01, "acknowledge");
   endtask : send

   task automatic wr(input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1);
      tisr_host_model_inst.start_cond();
      send({dev_addr, 1'b0});
      send(ra);
      send(d0);
      send(d1);
      tisr_host_model_inst.stop_cond();
   endtask : wr

   task automatic rdchk(input logic [7:0] ra, input logic [7:0] e0, input logic [7:0] e1, input string what);
      logic [7:0] r0, r1;
      tisr_host_model_inst.start_cond();
      send({dev_addr, 1'b0});
      send(ra);
      tisr_host_model_inst.start_cond();
      send({dev_addr, 1'b1});
      tisr_host_model_inst.rbyte(1'b0, r0);
      tisr_host_model_inst.rbyte(1'b1, r1);
      tisr_host_model_inst.stop_cond();
      check(r0, e0, what);
      check(r1, e1, what);
   endtask : rdchk

   initial begin
      {reset_n, nvm_addr_valid, wheel_ccw, evt} = '0;
      {wheel_cw, wheel_touched, button_release_report_en} = 3'h7;
      nvm_slave_addr = 7'h31;
      dev_addr = tisr_pkg::DEFAULT_SLAVE_ADDR;
      buttons_touched = 8'hA5;
      wheel_position = 16'h1234;
      {input_pin_levels, input_pin_mode, param_memory_status} = 24'hF03C5A;
      {op_mode_status, dimmable_intensity_rd} = 16'h01C7;
      repeat (5) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 check({7'h00, interrupt_out_n}, 8'h01, "idle interrupt");
      rdchk(8'h01, 8'h50, 8'hA5, "wheel and buttons");
      rdchk(8'h03, 8'h12, 8'h34, "position");
      rdchk(8'h05, 8'h00, 8'h00, "reserved");
      rdchk(8'h07, 8'h30, 8'h5A, "pins and memory");
      rdchk(8'h0B, 8'h00, 8'hC7, "control and intensity");
      $display("Test status reads done");
      tisr_host_model_inst.start_cond();
      tisr_host_model_inst.wbyte({7'h2C, 1'b0}, a);
      tisr_host_model_inst.stop_cond();
      check({7'h00, a}, 8'h00, "foreign address");
      @(posedge clk);
      #1 nvm_addr_valid = 1'b1;
      dev_addr = 7'h31;
      rdchk(8'h02, 8'hA5, 8'h12, "memory address");
      @(posedge clk);
      #1 nvm_addr_valid = 1'b0;
      dev_addr = tisr_pkg::DEFAULT_SLAVE_ADDR;
      $display("Test addressing done");
      wr(8'h0A, 8'h55, 8'hAA);
      wr(8'hAC, 8'h12, 8'h34);
      wr(8'h01, 8'hFF, 8'h00);
      wr(8'h08, 8'h77, 8'h9C);
      wr(8'h0C, 8'h66, 8'h21);
      wr(8'h0E, 8'h78, 8'h11);
      wr(8'hB0, 8'h00, 8'hDE);
      check(output_pin_control, 8'h00, "before phase");
      rdchk(8'h0A, 8'h55, 8'hAA, "staged");
      rdchk(8'h01, 8'h50, 8'hA5, "read only");
      pulse(9'h100);
      @(posedge clk);
      #1 check(output_pin_control, 8'h55, "applied");
      check(dimmable_pin_select, 8'hAA, "applied");
      check(param_key_high, 8'h12, "applied");
      check(param_key_low, 8'h34, "applied");
      check(compensation_and_op_mode, 8'h9C, "applied");
      check(dimmable_pin_intensity, 8'h66, "applied");
      check(param_gateway_config, 8'h21, "applied");
      check(param_gateway_base, 8'h78, "applied");
      check(software_reset, 8'hDE, "applied");
      $display("Test writes done");
      for (int i = 0; i < 8; i++) begin
         pulse(9'h001 << i);
         repeat (2) @(posedge clk);
         check({7'h00, interrupt_out_n}, 8'h00, "interrupt low");
         rdchk(8'h00, (i == 7) ? 8'h04 : (8'h01 << i), 8'h50, "flag");
         check({7'h00, interrupt_out_n}, 8'h01, "interrupt released");
      end
      @(posedge clk);
      #1 button_release_report_en = 1'b0;
      pulse(9'h080);
      repeat (2) @(posedge clk);
      check({7'h00, interrupt_out_n}, 8'h01, "unreported release");
      pulse(9'h048);
      rdchk(8'h00, 8'h48, 8'h50, "two flags");
      rdchk(8'h00, 8'h00, 8'h50, "flags cleared");
      $display("Test interrupts done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
